// ### dv/multiphase_power_state_pwm_chk.sv
// Purpose: port checks for the power-state sequencer
// Assumes: synchronous active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
`include "phase_pwm_defs.vh"
module multiphase_power_state_pwm_chk
(
   input wire clk_i, rst_b_i, osc_tick_i, target_change_fast_cmd_i,
   input wire target_change_slow_cmd_i, fast_trigger_i, current_limit_i,
   input wire ripple_threshold_i, sync_mode_out_o, ripple_controlled_mode_o,
   input wire count_fixed_o,
   input wire [1:0] power_state_i, phase1_drive_o, phase2_drive_o,
   input wire [1:0] phase3_drive_o, phase4_drive_o,
   input wire [3:0] ramp_trip_i,
   input wire [2:0] phase_tied_high_i, phase_count_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
a_sync_low: assert property (
   !sync_mode_out_o |-> $past(power_state_i[1]))
   else $error("sync low outside states 2 and 3");
a_ripple_state: assert property (
   ripple_controlled_mode_o |-> $past(power_state_i) != 2'h0)
   else $error("ripple mode in full power state");
a_idle_mid: assert property (
   !count_fixed_o |-> phase1_drive_o == `DRV_MID
   && phase2_drive_o == `DRV_MID && phase3_drive_o == `DRV_MID)
   else $error("idle drive");
a_fixed_hold: assert property (
   count_fixed_o |=> count_fixed_o)
   else $error("count fixed flag dropped");
a_count_hold: assert property (
   count_fixed_o && $past(count_fixed_o) |-> $stable(phase_count_o))
   else $error("phase count changed");
a_count_range: assert property (
   phase_count_o >= 3'h1 && phase_count_o <= 3'h4)
   else $error("phase count out of range");
a_shed_mid: assert property (
   count_fixed_o && phase_count_o < 3'h4 |-> phase4_drive_o == `DRV_MID)
   else $error("disabled phase driven");
a_single_phase: assert property (
   ripple_controlled_mode_o [*6] |-> phase2_drive_o == `DRV_MID)
   else $error("second phase active in ripple mode");
endmodule // multiphase_power_state_pwm_chk
bind multiphase_power_state_pwm multiphase_power_state_pwm_chk u_chk (.*);

// ### dv/power_stage_model.sv
// Purpose: power stage stand-in tripping each high drive after a delay
// Assumes: one clock
// Notes: slow_i stretches the on-time
`timescale 1ns/1ps
`include "phase_pwm_defs.vh"
module power_stage_model
(
   input wire clk_i,
   input wire [7:0] drive_i,
   input wire slow_i,
   output reg [3:0] ramp_trip_o = 4'h0
);
reg [15:0] hist_r = 16'h0;
integer k;
always @(posedge clk_i)
begin
   for (k = 0; k < 4; k = k + 1)
      hist_r[k] <= drive_i[2*k +: 2] == `DRV_HIGH;
   hist_r[15:4] <= hist_r[11:0];
   ramp_trip_o <= slow_i ? hist_r[15:12] : hist_r[3:0];
end
endmodule // power_stage_model

// ### dv/test_multiphase_power_state_pwm.sv
// Purpose: self-checking bench for the power-state sequencer
// Assumes: 200 MHz clock, phase 4 tied high on the board
// Notes: count detection shortened to 8 cycles
`timescale 1ns/1ps
`include "phase_pwm_defs.vh"
module test_multiphase_power_state_pwm;
reg clk_i = 0, rst_b_i = 0, osc_tick_i = 0, fast_trigger_i = 0, slow = 0;
reg target_change_fast_cmd_i = 0, target_change_slow_cmd_i = 0;
reg current_limit_i = 0, ripple_threshold_i = 0, multi_r = 0, all_r = 0;
reg [1:0] power_state_i = 2'h0;
reg [2:0] phase_tied_high_i = 3'h4;
reg [3:0] hi_p = 4'h0, seen_r = 4'h0;
reg [31:0] r;
wire [1:0] phase1_drive_o, phase2_drive_o, phase3_drive_o, phase4_drive_o;
wire sync_mode_out_o, ripple_controlled_mode_o, count_fixed_o;
wire [2:0] phase_count_o;
wire [3:0] ramp_trip_i, rise;
wire [7:0] drv;
integer n_mismatch = 0, num_checks = 0, cyc = 0, i, k;
assign drv = {phase4_drive_o, phase3_drive_o, phase2_drive_o, phase1_drive_o};
assign rise = {drv[7:6] == 1, drv[5:4] == 1, drv[3:2] == 1, drv[1:0] == 1} & ~hi_p;
multiphase_power_state_pwm #(.DETECT_CYC(8)) dut (.*);
power_stage_model u_stage (.clk_i(clk_i), .drive_i(drv), .slow_i(slow),
   .ramp_trip_o(ramp_trip_i));
function [2:0] exp_count(input [2:0] t);
   exp_count = t[0] ? 3'h1 : t[1] ? 3'h2 : t[2] ? 3'h3 : 3'h4;
endfunction
function [1:0] exp_mode(input [1:0] st);
   exp_mode = {st < 2'h2, st != 2'h0};
endfunction
task chk(input ok);
begin
   num_checks = num_checks + 1;
   if (!ok)
   begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: output differs from expected", $time);
   end
end
endtask
task step(input integer n);
   repeat (n) @(posedge clk_i);
endtask
task wrap_up;
begin
   $display("checks %0d mismatches %0d", num_checks, n_mismatch);
   if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
   else
      $display("MISMATCHES SEEN");
   $finish;
end
endtask
initial forever #2.5 clk_i = ~clk_i;
always @(posedge clk_i)
begin
   hi_p <= rise | (hi_p & {drv[7:6] == 1, drv[5:4] == 1, drv[3:2] == 1, drv[1:0] == 1});
   seen_r <= seen_r | rise;
   if ($countones(rise) > 1) multi_r <= 1;
   if (rise == 4'h7) all_r <= 1;
   cyc = cyc + 1;
   if (cyc == 20000)
   begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
end
initial
begin
   r = $urandom(58979);
   step(5);
   rst_b_i <= 1;
   step(20);
   @(negedge clk_i);
   chk(count_fixed_o === 1'b1 && phase_count_o === exp_count(phase_tied_high_i));
   seen_r = 0;
   for (i = 0; i < 6; i = i + 1)
   begin
      osc_tick_i <= 1;
      step(3);
      osc_tick_i <= 0;
      step(17);
   end
   @(negedge clk_i);
   chk(seen_r === 4'h7 && multi_r === 1'b0);
   chk(drv === {`DRV_MID, 6'h0});
   slow <= 1;
   fast_trigger_i <= 1;
   step(8);
   fast_trigger_i <= 0;
   step(25);
   @(negedge clk_i);
   chk(all_r === 1'b1 && drv === {`DRV_MID, 6'h0});
   for (i = 0; i < 3; i = i + 1)
   begin
      power_state_i <= 2'h2;
      {current_limit_i, target_change_fast_cmd_i, target_change_slow_cmd_i} <= 3'h4 >> i;
      step(6);
      @(negedge clk_i);
      chk(ripple_controlled_mode_o === 1'b0 && sync_mode_out_o === 1'b1);
      {current_limit_i, target_change_fast_cmd_i, target_change_slow_cmd_i} <= 3'h0;
      step(6);
      @(negedge clk_i);
      chk(ripple_controlled_mode_o === 1'b1);
   end
   power_state_i <= 2'h1;
   slow <= 0;
   step(10);
   seen_r = 0;
   ripple_threshold_i <= 1;
   step(3);
   ripple_threshold_i <= 0;
   step(15);
   @(negedge clk_i);
   chk(seen_r === 4'h1);
   for (i = 0; i < 40; i = i + 1)
   begin
      r = $urandom;
      {power_state_i, osc_tick_i, ripple_threshold_i} <= r[3:0];
      step(2);
      @(negedge clk_i);
      chk({sync_mode_out_o, ripple_controlled_mode_o} ===
         exp_mode(power_state_i));
   end
   // ==========================================
   // mid-run enable drop, phase count caught again
   rst_b_i <= 0;
   power_state_i <= 2'h0;
   osc_tick_i <= 0;
   ripple_threshold_i <= 0;
   phase_tied_high_i <= 3'h2;
   step(3);
   @(negedge clk_i);
   chk(drv === 8'haa && count_fixed_o === 1'b0);
   rst_b_i <= 1;
   step(20);
   @(negedge clk_i);
   chk(count_fixed_o === 1'b1 &&
      phase_count_o === exp_count(phase_tied_high_i));
   wrap_up;
end
endmodule // test_multiphase_power_state_pwm

// ### include/phase_pwm_defs.vh
// Purpose: constants for the four-phase sequencing and power-state block
// Assumes: 200 MHz clock
// Notes: tri-state drive is encoded as two bits per phase
`ifndef PHASE_PWM_DEFS_VH
`define PHASE_PWM_DEFS_VH
// ==========================================
// drive codes (per phase, 2 bits)
`define DRV_LOW 2'h0
`define DRV_HIGH 2'h1
`define DRV_MID 2'h2
// ==========================================
// power states
`define FULL_POWER_STATE 2'h0
`define LOW_CURRENT_STATE 2'h1
`define SLEEP_CURRENT_STATE 2'h2
`define ULTRA_LOW_CURRENT_STATE 2'h3
// ==========================================
// timing
`define CLK_MHZ 200
`define PHASE_DETECT_US 50
`define PHASE_DETECT_CYC (`PHASE_DETECT_US * `CLK_MHZ)
`define OSC_DIV_RESET 8'h3f
`define PHASE_MAX 4
`endif

// ### src/multiphase_power_state_pwm.v
// Purpose: phase sequencing and power-state control, four-phase buck
// Assumes: comparator inputs are asynchronous and pass two flip-flops
// Notes: rst_b_i is the chip enable; phase count caught after release
// Operation
// - fixed-frequency mode sets a phase high on its phase clock pulse
// - a phase clears when its combined ramp reaches the error level
// - phase clock pulses of active phases are spaced apart in time
// - in fixed-frequency mode fast trigger sets all active phases high at once, no offset
// - during fast turn-on each phase still clears on its own trip
// - state 0 runs all enabled phases fixed-frequency on master clock
// - states 1 to 3 run phase 1 only, others held inactive
// - a target change in progress forces state 0 full-phase operation
// - states other than 0 use ripple-controlled single-phase mode
// - states 2 and 3 drive sync-mode output low for diode emulation
// - over-current clearing before latch-off returns to ripple mode
// - sync high in states 0,1; fixed-frequency only in state 0
// - power-state code decodes as binary; 11 is ultra-low state
// - phase count of one to four forms the full-phase set
// - phases tied high are sensed once at enable; count then fixed
// - current limit forces full-phase fixed-frequency in any state
// - ripple mode sets phase 1 at threshold, clears on ramp trip
// - per-phase rate is master clock divided by active phase count
`timescale 1ns/1ps
`include "phase_pwm_defs.vh"
module multiphase_power_state_pwm
#(
   parameter DETECT_CYC = `PHASE_DETECT_CYC
)
(
   input wire clk_i,
   input wire rst_b_i,
   input wire osc_tick_i,
   input wire [1:0] power_state_i,
   input wire target_change_fast_cmd_i,
   input wire target_change_slow_cmd_i,
   input wire fast_trigger_i,
   input wire current_limit_i,
   input wire ripple_threshold_i,
   input wire [3:0] ramp_trip_i,
   input wire [2:0] phase_tied_high_i,
   output reg [1:0] phase1_drive_o,
   output reg [1:0] phase2_drive_o,
   output reg [1:0] phase3_drive_o,
   output reg [1:0] phase4_drive_o,
   output reg sync_mode_out_o,
   output reg ripple_controlled_mode_o,
   output reg [2:0] phase_count_o,
   output reg count_fixed_o
);
   // ==========================================
   // input synchronisers
   reg [9:0] meta_r;
   reg [9:0] sync_r;
   reg [2:0] tie_meta_r;
   reg [2:0] tie_sync_r;
   always @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         meta_r <= 10'h000;
         sync_r <= 10'h000;
         tie_meta_r <= 3'h0;
         tie_sync_r <= 3'h0;
      end
      else
      begin
         meta_r <= {osc_tick_i, fast_trigger_i, current_limit_i,
            ripple_threshold_i, ramp_trip_i, target_change_fast_cmd_i,
            target_change_slow_cmd_i};
         sync_r <= meta_r;
         tie_meta_r <= phase_tied_high_i;
         tie_sync_r <= tie_meta_r;
      end
   end
   wire osc_s = sync_r[9];
   wire fast_s = sync_r[8];
   wire limit_s = sync_r[7];
   wire thr_s = sync_r[6];
   wire [3:0] trip_s = sync_r[5:2];
   wire change_s = sync_r[1] | sync_r[0];
   // ==========================================
   // phase count detection at enable
   reg [13:0] det_cnt_r;
   reg [2:0] count_r;
   reg fixed_r;
   always @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         det_cnt_r <= 14'h0000;
         count_r <= 3'h1;
         fixed_r <= 1'b0;
      end
      else if (!fixed_r)
      begin
         if (det_cnt_r == DETECT_CYC[13:0] - 14'h0001)
         begin
            fixed_r <= 1'b1;
            if (tie_sync_r[0])
               count_r <= 3'h1;
            else if (tie_sync_r[1])
               count_r <= 3'h2;
            else if (tie_sync_r[2])
               count_r <= 3'h3;
            else
               count_r <= 3'h4;
         end
         else
            det_cnt_r <= det_cnt_r + 14'h0001;
      end
   end
   // ==========================================
   // power-state decode
   reg full_mode;
   reg sync_nxt;
   always @*
   begin
      full_mode = (power_state_i == `FULL_POWER_STATE);
      if (change_s)
         full_mode = 1'b1;
      if (limit_s)
         full_mode = 1'b1;
      sync_nxt = (power_state_i == `FULL_POWER_STATE) ||
         (power_state_i == `LOW_CURRENT_STATE);
      if (full_mode)
         sync_nxt = 1'b1;
      if (power_state_i == `SLEEP_CURRENT_STATE ||
         power_state_i == `ULTRA_LOW_CURRENT_STATE)
         sync_nxt = sync_nxt & full_mode;
   end
   // ==========================================
   // phase sequencer: master ticks rotate through active phases
   reg [1:0] slot_r;
   reg osc_d_r;
   wire osc_pulse = osc_s & ~osc_d_r;
   reg thr_d_r;
   wire thr_pulse = thr_s & ~thr_d_r;
   reg fast_d_r;
   wire fast_pulse = fast_s & ~fast_d_r;
   always @(posedge clk_i)
   begin
      if (!rst_b_i || !fixed_r)
      begin
         slot_r <= 2'h0;
         osc_d_r <= 1'b0;
         thr_d_r <= 1'b0;
         fast_d_r <= 1'b0;
      end
      else
      begin
         osc_d_r <= osc_s;
         thr_d_r <= thr_s;
         fast_d_r <= fast_s;
         if (osc_pulse && full_mode)
         begin
            if ({1'b0, slot_r} >= count_r - 3'h1)
               slot_r <= 2'h0;
            else
               slot_r <= slot_r + 2'h1;
         end
      end
   end
   reg [3:0] active;
   reg [3:0] set_v;
   integer k;
   always @*
   begin
      active = 4'h0;
      set_v = 4'h0;
      for (k = 0; k < `PHASE_MAX; k = k + 1)
      begin
         if (fixed_r && (k == 0 || (full_mode && k < count_r)))
            active[k] = 1'b1;
         if (full_mode && osc_pulse && slot_r == k)
            set_v[k] = 1'b1;
         if (full_mode && fast_pulse)
            set_v[k] = 1'b1;
      end
      if (!full_mode && thr_pulse)
         set_v[0] = 1'b1;
      set_v = set_v & active;
   end
   // ==========================================
   // phase drive latches
   wire [1:0] drv [0:3];
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : ph
         phase_slice u_slice
         (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .active_i(active[g]),
            .set_i(set_v[g]),
            .trip_i(trip_s[g]),
            .drive_o(drv[g])
         );
      end
   endgenerate
   // ==========================================
   // registered outputs
   always @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         phase1_drive_o <= `DRV_MID;
         phase2_drive_o <= `DRV_MID;
         phase3_drive_o <= `DRV_MID;
         phase4_drive_o <= `DRV_MID;
         sync_mode_out_o <= 1'b1;
         ripple_controlled_mode_o <= 1'b0;
         phase_count_o <= 3'h1;
         count_fixed_o <= 1'b0;
      end
      else
      begin
         phase1_drive_o <= drv[0];
         phase2_drive_o <= drv[1];
         phase3_drive_o <= drv[2];
         phase4_drive_o <= drv[3];
         sync_mode_out_o <= sync_nxt;
         ripple_controlled_mode_o <= ~full_mode;
         phase_count_o <= count_r;
         count_fixed_o <= fixed_r;
      end
   end
endmodule // multiphase_power_state_pwm

// ### src/phase_slice.v
// Purpose: one phase's set/clear drive latch
// Assumes: set and trip are synchronous single-clock signals
// Notes: trip wins over set in the same cycle, whether or not already high
`timescale 1ns/1ps
`include "phase_pwm_defs.vh"
module phase_slice
(
   input wire clk_i,
   input wire rst_b_i,
   input wire active_i,
   input wire set_i,
   input wire trip_i,
   output reg [1:0] drive_o
);
   reg [1:0] drive_nxt;
   always @*
   begin
      drive_nxt = drive_o;
      if (!active_i)
         drive_nxt = `DRV_MID;
      else if (trip_i)
         drive_nxt = `DRV_LOW;
      else if (set_i)
         drive_nxt = `DRV_HIGH;
      else if (drive_o == `DRV_MID)
         drive_nxt = `DRV_LOW;
   end
   always @(posedge clk_i)
   begin
      if (!rst_b_i)
         drive_o <= `DRV_MID;
      else
         drive_o <= drive_nxt;
   end
endmodule // phase_slice
